// File: hdl/ulm_pkg.sv
// Purpose: constants, register map and carriers for the line-mode block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   offsets are byte addresses
package ulm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_LINE_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_LINE_MODE        = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE       = 8'h08;
  localparam logic [7:0] OFF_IRQ_DISABLE      = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK         = 8'h10;
  localparam logic [7:0] OFF_CHANNEL_STATUS   = 8'h14;
  localparam logic [7:0] OFF_RECEIVE_HOLDING  = 8'h18;
  localparam logic [7:0] OFF_TRANSMIT_HOLDING = 8'h1C;
  localparam logic [7:0] OFF_BAUD_DIVIDER     = 8'h20;
  localparam logic [7:0] OFF_RX_TIMEOUT       = 8'h24;
  localparam logic [7:0] OFF_TX_TIMEGUARD     = 8'h28;
  localparam logic [7:0] OFF_CLOCK_RATIO      = 8'h40;
  localparam logic [7:0] OFF_ERROR_COUNT      = 8'h44;
  localparam logic [7:0] OFF_INFRARED_FILTER  = 8'h4C;

  // line_control command bits
  localparam int CMD_RST_RX  = 2;
  localparam int CMD_RST_TX  = 3;
  localparam int CMD_RX_EN   = 4;
  localparam int CMD_RX_DIS  = 5;
  localparam int CMD_TX_EN   = 6;
  localparam int CMD_TX_DIS  = 7;
  localparam int CMD_DTR_EN  = 16;
  localparam int CMD_DTR_DIS = 17;
  localparam int CMD_RTS_EN  = 18;
  localparam int CMD_RTS_DIS = 19;

  // line_mode fields
  localparam int MODE_LSB    = 0;
  localparam int CLKSEL_LSB  = 4;
  localparam int CHANNEL_MODE_FIELD_LSB  = 14;

  localparam logic [3:0] OPMODE_NORMAL  = 4'h0;
  localparam logic [3:0] OPMODE_RS485   = 4'h1;
  localparam logic [3:0] OPMODE_MODEM   = 4'h3;
  localparam logic [3:0] OPMODE_IRDA    = 4'h8;

  localparam logic [1:0] CLKSEL_DIV8    = 2'h1;
  localparam logic [1:0] CHANNEL_MODE_FIELD_NORMAL  = 2'h0;
  localparam logic [1:0] CHANNEL_MODE_FIELD_ECHO    = 2'h1;
  localparam logic [1:0] CHANNEL_MODE_FIELD_LOCAL   = 2'h2;
  localparam logic [1:0] CHANNEL_MODE_FIELD_REMOTE  = 2'h3;

  // channel_status fields
  localparam int CSR_TX_EMPTY   = 9;
  localparam int CSR_CHANGE_LSB = 16;
  localparam int CSR_LEVEL_LSB  = 20;

  // Reset values and timing counts
  localparam logic [10:0] CLOCK_RATIO_RESET = 11'h174;
  localparam logic [2:0]  PRESCALE_LAST     = 3'h7;
  localparam logic [3:0]  TICK_LAST         = 4'hF;
  localparam logic [3:0]  IR_PULSE_TICKS    = 4'h3;

  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Modem inputs, bit 0 ring up to bit 3 clear-to-send
  typedef struct packed {
    logic cts;
    logic dcd;
    logic dsr;
    logic ri;
  } ulm_modem_t;

  // From the character engine, same clock
  typedef struct packed {
    logic       tx_serial;
    logic       tx_empty;
    logic       tx_busy;
    logic [8:0] rx_data;
    logic [7:0] err_count;
  } ulm_eng_in_t;

  // To the character engine
  typedef struct packed {
    logic       tx_enable;
    logic       rx_enable;
    logic       rx_serial;
    logic       tick16;
    logic       rst_tx;
    logic       rst_rx;
    logic       tx_load;
    logic [8:0] tx_data;
    logic       err_clear;
  } ulm_eng_out_t;

endpackage

// File: hdl/ulm_line_modes.sv
// Purpose: line modes of a serial transceiver: infrared, RS485, modem, test loops
// Assumes: character engine on the same clock; pins asynchronous
// Notes:   registers over AXI4-Lite; clk_en low freezes all state except the filter and timeguard clears on reset commands
// Function
// - Infrared filter is an 8-bit down counter loaded from infrared_filter.
// - Receive falling edge starts the counter, one step per master clock.
// - Receive rising edge while running stops and reloads the counter.
// - Counter at zero holds receiver input low for one bit period.
// - Operating mode 0x8 enables infrared modulator and demodulator.
// - Operating mode 0x1 enables RS485, other settings unchanged.
// - In RS485 mode RTS is the inverse of transmitter empty.
// - In RS485 mode RTS stays high through a programmed timeguard.
// - Operating mode 0x3 is modem mode with asynchronous framing.
// - Terminal-ready disable drives DTR high, enable drives it low.
// - In modem mode RTS is driven automatically.
// - Level change on RI, DSR, DCD or CTS sets its change flag.
// - Reading channel_status clears the change flags.
// - In modem mode inactive CTS disables transmitter after the current character.
// - Two-bit channel mode: normal, echo, local loop, remote loop.
// - Normal mode: receive pin to receiver, transmitter to transmit pin.
// - Echo mode: received bits go to transmit pin, receiver still runs.
// - Local loop: transmitter to receiver, transmit pin held high.
// - Remote loop: receive pin to transmit pin, transmitter and receiver off.
`timescale 1ns/100ps
module ulm_line_modes (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  input  wire logic [7:0]            awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [7:0]            araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  rxd_pin,
  input  wire ulm_pkg::ulm_modem_t   modem_pins,
  output logic                       txd_pin,
  output logic                       rts_pin,
  output logic                       dtr_pin,
  output logic                       change_event,
  input  wire ulm_pkg::ulm_eng_in_t  eng_in,
  output ulm_pkg::ulm_eng_out_t      eng_out
);

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    case (a)
      ulm_pkg::OFF_LINE_CONTROL, ulm_pkg::OFF_LINE_MODE, ulm_pkg::OFF_IRQ_ENABLE,
      ulm_pkg::OFF_IRQ_DISABLE, ulm_pkg::OFF_IRQ_MASK, ulm_pkg::OFF_CHANNEL_STATUS,
      ulm_pkg::OFF_RECEIVE_HOLDING, ulm_pkg::OFF_TRANSMIT_HOLDING,
      ulm_pkg::OFF_BAUD_DIVIDER, ulm_pkg::OFF_RX_TIMEOUT, ulm_pkg::OFF_TX_TIMEGUARD,
      ulm_pkg::OFF_CLOCK_RATIO, ulm_pkg::OFF_ERROR_COUNT,
      ulm_pkg::OFF_INFRARED_FILTER: known_addr = 1'b1;
      default:                      known_addr = 1'b0;
    endcase
  endfunction

  // Registers
  logic [31:0]          line_mode;
  logic [15:0]          baud_divider;
  logic [15:0]          rx_timeout;
  logic [7:0]           tx_timeguard;
  logic [10:0]          clock_ratio_field;
  logic [7:0]           infrared_filter;
  logic [3:0]           irq_mask;
  logic [3:0]           change_flags;

  // Bus holding state
  logic                 aw_hold;
  logic                 w_hold;
  logic [7:0]           aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 wr_fire;
  logic                 rd_fire;
  logic [31:0]          wmask;
  logic [31:0]          cmd;
  logic                 csr_read;

  // Synchronisers
  logic                 rxd_meta;
  logic                 rxd_s;
  logic                 rxd_d;
  ulm_pkg::ulm_modem_t  modem_meta;
  ulm_pkg::ulm_modem_t  modem_s;
  ulm_pkg::ulm_modem_t  modem_d;

  // Line state
  logic [3:0]           op_mode;
  logic [1:0]           channel_mode_field;
  logic                 is_irda;
  logic [2:0]           pre_cnt;
  logic [15:0]          cd_cnt;
  logic                 tick16;
  logic [3:0]           bit_phase;
  logic                 bit_end;
  logic [7:0]           filt_cnt;
  logic                 filt_run;
  logic                 ir_low;
  logic [3:0]           ir_hold_cnt;
  logic                 tx_empty_d;
  logic                 tg_active;
  logic [7:0]           tg_cnt;
  logic                 tx_en;
  logic                 rx_en;
  logic                 rts_cmd;
  logic                 line_in;
  logic                 next_txd;
  logic                 next_rx;
  logic                 next_rts;

  assign op_mode = line_mode[ulm_pkg::MODE_LSB +: 4];
  assign channel_mode_field  = line_mode[ulm_pkg::CHANNEL_MODE_FIELD_LSB +: 2];
  assign is_irda = (op_mode == ulm_pkg::OPMODE_IRDA);
  assign wr_fire = aw_hold && w_hold && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wmask   = strb_mask(w_strb_q);
  assign cmd     = (wr_fire && aw_addr_q == ulm_pkg::OFF_LINE_CONTROL) ? (w_data_q & wmask)
                                                                     : 32'h0000_0000;
  assign csr_read = rd_fire && (araddr == ulm_pkg::OFF_CHANNEL_STATUS);
  assign bit_end = tick16 && (bit_phase == ulm_pkg::TICK_LAST);

  // AXI write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= ulm_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (!aw_hold && !bvalid)
        awready <= !(awvalid && awready);
      if (!w_hold && !bvalid)
        wready <= !(wvalid && wready);
      if (awvalid && awready)
      begin
        aw_hold   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= known_addr(aw_addr_q) ? ulm_pkg::RESP_OKAY : ulm_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Writable registers, byte enables honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_mode         <= 32'h0000_0000;
      baud_divider      <= 16'h0000;
      rx_timeout        <= 16'h0000;
      tx_timeguard      <= 8'h00;
      clock_ratio_field <= ulm_pkg::CLOCK_RATIO_RESET;
      infrared_filter   <= 8'h00;
      irq_mask          <= 4'h0;
    end
    else if (clk_en && wr_fire)
    begin
      case (aw_addr_q)
        ulm_pkg::OFF_LINE_MODE:
          line_mode <= (line_mode & ~wmask) | (w_data_q & wmask);
        ulm_pkg::OFF_BAUD_DIVIDER:
          baud_divider <= (baud_divider & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        ulm_pkg::OFF_RX_TIMEOUT:
          rx_timeout <= (rx_timeout & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
        ulm_pkg::OFF_TX_TIMEGUARD:
          tx_timeguard <= (tx_timeguard & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
        ulm_pkg::OFF_CLOCK_RATIO:
          clock_ratio_field <= (clock_ratio_field & ~wmask[10:0])
                               | (w_data_q[10:0] & wmask[10:0]);
        ulm_pkg::OFF_INFRARED_FILTER:
          infrared_filter <= (infrared_filter & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
        ulm_pkg::OFF_IRQ_ENABLE:
          irq_mask <= irq_mask | (w_data_q[ulm_pkg::CSR_CHANGE_LSB +: 4]
                                  & wmask[ulm_pkg::CSR_CHANGE_LSB +: 4]);
        ulm_pkg::OFF_IRQ_DISABLE:
          irq_mask <= irq_mask & ~(w_data_q[ulm_pkg::CSR_CHANGE_LSB +: 4]
                                   & wmask[ulm_pkg::CSR_CHANGE_LSB +: 4]);
        default:
          irq_mask <= irq_mask;
      endcase
    end
  end

  // AXI read channel, one cycle to answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ulm_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_fire)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= known_addr(araddr) ? ulm_pkg::RESP_OKAY : ulm_pkg::RESP_SLVERR;
        case (araddr)
          ulm_pkg::OFF_LINE_MODE:       rdata <= line_mode;
          ulm_pkg::OFF_IRQ_MASK:        rdata <= {12'h000, irq_mask, 16'h0000};
          ulm_pkg::OFF_CHANNEL_STATUS:
            rdata <= {8'h00, modem_s, change_flags, 6'h00, eng_in.tx_empty, 9'h000};
          ulm_pkg::OFF_RECEIVE_HOLDING: rdata <= {23'h000000, eng_in.rx_data};
          ulm_pkg::OFF_BAUD_DIVIDER:    rdata <= {16'h0000, baud_divider};
          ulm_pkg::OFF_RX_TIMEOUT:      rdata <= {16'h0000, rx_timeout};
          ulm_pkg::OFF_TX_TIMEGUARD:    rdata <= {24'h000000, tx_timeguard};
          ulm_pkg::OFF_CLOCK_RATIO:     rdata <= {21'h000000, clock_ratio_field};
          ulm_pkg::OFF_ERROR_COUNT:     rdata <= {24'h000000, eng_in.err_count};
          ulm_pkg::OFF_INFRARED_FILTER: rdata <= {24'h000000, infrared_filter};
          default:                      rdata <= 32'h0000_0000;
        endcase
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
      else if (!rvalid)
        arready <= 1'b1;
    end
  end

  // Two flip-flops before any logic sees a pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxd_meta   <= 1'b1;
      rxd_s      <= 1'b1;
      rxd_d      <= 1'b1;
      modem_meta <= '0;
      modem_s    <= '0;
      modem_d    <= '0;
    end
    else if (clk_en)
    begin
      rxd_meta   <= rxd_pin;
      rxd_s      <= rxd_meta;
      rxd_d      <= rxd_s;
      modem_meta <= modem_pins;
      modem_s    <= modem_meta;
      modem_d    <= modem_s;
    end
  end

  // Change flags; a change in the read cycle survives the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      change_flags <= 4'h0;
      change_event <= 1'b0;
    end
    else if (clk_en)
    begin
      change_flags <= (change_flags & ~{4{csr_read}}) | (modem_s ^ modem_d);
      change_event <= |(change_flags & irq_mask);
    end
  end

  // Baud generator: 16 ticks per bit, divider 0 stops it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_cnt   <= 3'h0;
      cd_cnt    <= 16'h0000;
      tick16    <= 1'b0;
      bit_phase <= 4'h0;
    end
    else if (clk_en)
    begin
      pre_cnt <= pre_cnt + 3'h1;
      tick16  <= 1'b0;
      if (baud_divider == 16'h0000)
        cd_cnt <= 16'h0000;
      else if (line_mode[ulm_pkg::CLKSEL_LSB +: 2] != ulm_pkg::CLKSEL_DIV8
               || pre_cnt == ulm_pkg::PRESCALE_LAST)
      begin
        if (cd_cnt >= baud_divider - 16'h0001)
        begin
          cd_cnt <= 16'h0000;
          tick16 <= 1'b1;
        end
        else
          cd_cnt <= cd_cnt + 16'h0001;
      end
      if (tick16)
        bit_phase <= bit_phase + 4'h1;
    end
  end

  // Infrared receive filter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd[ulm_pkg::CMD_RST_RX])
    begin
      filt_cnt    <= 8'h00;
      filt_run    <= 1'b0;
      ir_low      <= 1'b0;
      ir_hold_cnt <= 4'h0;
    end
    else if (clk_en)
    begin
      if (!is_irda)
      begin
        filt_run <= 1'b0;
        ir_low   <= 1'b0;
      end
      else if (rxd_d && !rxd_s)
      begin
        filt_cnt <= infrared_filter;
        filt_run <= 1'b1;
      end
      else if (filt_run)
      begin
        if (!rxd_d && rxd_s)
        begin
          filt_run <= 1'b0;
          filt_cnt <= infrared_filter;
        end
        else if (filt_cnt == 8'h00)
        begin
          filt_run    <= 1'b0;
          filt_cnt    <= infrared_filter;
          ir_low      <= 1'b1;
          ir_hold_cnt <= 4'h0;
        end
        else
          filt_cnt <= filt_cnt - 8'h01;
      end
      if (ir_low && tick16)
      begin
        ir_hold_cnt <= ir_hold_cnt + 4'h1;
        if (ir_hold_cnt == ulm_pkg::TICK_LAST)
          ir_low <= 1'b0;
      end
    end
  end

  // Timeguard tail keeps the RS485 driver on
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd[ulm_pkg::CMD_RST_TX])
    begin
      tx_empty_d <= 1'b1;
      tg_active  <= 1'b0;
      tg_cnt     <= 8'h00;
    end
    else if (clk_en)
    begin
      tx_empty_d <= eng_in.tx_empty;
      if (!eng_in.tx_empty)
        tg_active <= 1'b0;
      else if (!tx_empty_d && tx_timeguard != 8'h00)
      begin
        tg_active <= 1'b1;
        tg_cnt    <= tx_timeguard;
      end
      else if (tg_active && bit_end)
      begin
        tg_cnt <= tg_cnt - 8'h01;
        if (tg_cnt == 8'h01)
          tg_active <= 1'b0;
      end
    end
  end

  // Enables and modem outputs from commands
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_en   <= 1'b0;
      rx_en   <= 1'b0;
      dtr_pin <= 1'b1;
      rts_cmd <= 1'b1;
    end
    else if (clk_en)
    begin
      if (cmd[ulm_pkg::CMD_RX_DIS] || cmd[ulm_pkg::CMD_RST_RX])
        rx_en <= 1'b0;
      else if (cmd[ulm_pkg::CMD_RX_EN])
        rx_en <= 1'b1;
      // CTS stop waits for a character gap so none is cut short; disable and reset commands stop at once
      if (cmd[ulm_pkg::CMD_TX_DIS] || cmd[ulm_pkg::CMD_RST_TX])
        tx_en <= 1'b0;
      else if (op_mode == ulm_pkg::OPMODE_MODEM && modem_s.cts && !eng_in.tx_busy)
        tx_en <= 1'b0;
      else if (cmd[ulm_pkg::CMD_TX_EN])
        tx_en <= 1'b1;
      if (cmd[ulm_pkg::CMD_DTR_DIS])
        dtr_pin <= 1'b1;
      else if (cmd[ulm_pkg::CMD_DTR_EN])
        dtr_pin <= 1'b0;
      if (cmd[ulm_pkg::CMD_RTS_DIS])
        rts_cmd <= 1'b1;
      else if (cmd[ulm_pkg::CMD_RTS_EN])
        rts_cmd <= 1'b0;
    end
  end

  // Pin routing per channel mode
  always_comb
  begin
    line_in  = is_irda ? !ir_low : rxd_s;
    next_txd = is_irda ? (!eng_in.tx_serial && bit_phase < ulm_pkg::IR_PULSE_TICKS)
                       : eng_in.tx_serial;
    next_rx  = line_in;
    case (channel_mode_field)
      ulm_pkg::CHANNEL_MODE_FIELD_NORMAL: next_txd = next_txd;
      ulm_pkg::CHANNEL_MODE_FIELD_ECHO:   next_txd = line_in;
      ulm_pkg::CHANNEL_MODE_FIELD_LOCAL:
      begin
        next_txd = 1'b1;
        next_rx  = eng_in.tx_serial;
      end
      ulm_pkg::CHANNEL_MODE_FIELD_REMOTE: next_txd = rxd_s;
      default:                next_txd = 1'b1;
    endcase
    case (op_mode)
      ulm_pkg::OPMODE_RS485: next_rts = !eng_in.tx_empty || tg_active;
      ulm_pkg::OPMODE_MODEM: next_rts = !tx_en;
      default:               next_rts = rts_cmd;
    endcase
  end

  // Registered pins and engine controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_pin <= 1'b1;
      rts_pin <= 1'b1;
      eng_out <= '0;
    end
    else if (clk_en)
    begin
      txd_pin           <= next_txd;
      rts_pin           <= next_rts;
      eng_out.tx_enable <= tx_en && channel_mode_field != ulm_pkg::CHANNEL_MODE_FIELD_REMOTE;
      eng_out.rx_enable <= rx_en && channel_mode_field != ulm_pkg::CHANNEL_MODE_FIELD_REMOTE;
      eng_out.rx_serial <= next_rx;
      eng_out.tick16    <= tick16;
      eng_out.rst_tx    <= cmd[ulm_pkg::CMD_RST_TX];
      eng_out.rst_rx    <= cmd[ulm_pkg::CMD_RST_RX];
      eng_out.tx_load   <= wr_fire && aw_addr_q == ulm_pkg::OFF_TRANSMIT_HOLDING;
      if (wr_fire && aw_addr_q == ulm_pkg::OFF_TRANSMIT_HOLDING)
        eng_out.tx_data <= w_data_q[8:0];
      eng_out.err_clear <= rd_fire && araddr == ulm_pkg::OFF_ERROR_COUNT;
    end
  end

endmodule

// File: bench/ulm_line_modes_properties.sv
// Purpose: port timing checks for the line-mode block
// Assumes: address and data of a write offered together
// Notes:   mode copy tracked from bus handshakes, one cycle ahead of line_mode
`timescale 1ns/100ps
module ulm_line_modes_properties (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [7:0]            awaddr,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic [31:0]           wdata,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic                  rxd_pin,
  input wire ulm_pkg::ulm_modem_t   modem_pins,
  input wire logic                  txd_pin,
  input wire logic                  rts_pin,
  input wire logic                  dtr_pin,
  input wire ulm_pkg::ulm_eng_in_t  eng_in,
  input wire ulm_pkg::ulm_eng_out_t eng_out
);
  logic [15:0] md;
  logic [15:0] md_q;
  wire hs = awvalid & awready & wvalid & wready;
  // Settled mode only, so a mode change never trips a check
  wire st = md == md_q;
  wire rs = st & md[3:0] == ulm_pkg::OPMODE_RS485;
  wire mm = st & md[3:0] == ulm_pkg::OPMODE_MODEM;
  wire lp = st & md[15:14] == ulm_pkg::CHANNEL_MODE_FIELD_LOCAL;
  wire rm = st & md[15:14] == ulm_pkg::CHANNEL_MODE_FIELD_REMOTE;
  wire ec = st & md[15:14] == ulm_pkg::CHANNEL_MODE_FIELD_ECHO;
  always_ff @(posedge aclk)
  begin
    md_q <= aresetn ? md : 16'h0000;
    if (!aresetn)
      md <= 16'h0000;
    else if (hs && awaddr == ulm_pkg::OFF_LINE_MODE)
      md <= wdata[15:0];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ctl(b, o);
    hs && awaddr == ulm_pkg::OFF_LINE_CONTROL && wdata[b] && !wdata[o];
  endsequence
  chk_dtr_high: assert property (s_ctl(17, 16) |-> ##[1:4] dtr_pin)
    else $error("dtr not high");
  chk_dtr_low: assert property (s_ctl(16, 17) |-> ##[1:4] !dtr_pin)
    else $error("dtr not low");
  chk_rs485_rts: assert property ((rs && !eng_in.tx_empty)[*3] |=> rts_pin)
    else $error("rts low while sending");
  chk_modem_rts:
    assert property ((mm && $stable(eng_out.tx_enable))[*3] |-> rts_pin == !eng_out.tx_enable)
    else $error("modem rts wrong");
  chk_cts_stop:
    assert property ((mm && modem_pins.cts && !eng_in.tx_busy)[*4] |=> !eng_out.tx_enable)
    else $error("cts did not stop tx");
  chk_cts_finish:
    assert property (mm && eng_in.tx_busy && eng_out.tx_enable |=> eng_out.tx_enable)
    else $error("tx stopped mid character");
  chk_local_idle: assert property (lp[*2] |=> txd_pin)
    else $error("txd not idle");
  chk_remote_off:
    assert property (rm[*2] |=> !eng_out.tx_enable && !eng_out.rx_enable)
    else $error("remote loop left engine on");
  chk_echo_follow:
    assert property (((ec || rm) && $stable(rxd_pin))[*6] |-> txd_pin == rxd_pin)
    else $error("txd not echoing");
endmodule
bind ulm_line_modes ulm_line_modes_properties chk (.*);

// File: bench/ulm_far_end.sv
// Purpose: far-end line and modem model
// Assumes: receive line idles high
// Notes:   pulse only while no pulse runs, to avoid a write race
`timescale 1ns/100ps
module ulm_far_end (
  input  wire logic           aclk,
  output logic                rxd_pin,
  output ulm_pkg::ulm_modem_t modem_pins
);
  logic lvl = 1'h1;
  int   hold = 0;
  initial modem_pins = 4'h0;
  assign rxd_pin = lvl && hold == 0;
  always @(posedge aclk)
    if (hold > 0)
      hold <= hold - 1;
  task automatic pulse(input int n);
    hold <= n;
  endtask
  task automatic lines(input logic l, input ulm_pkg::ulm_modem_t m);
    lvl <= l;
    modem_pins <= m;
  endtask
endmodule

// File: bench/tb_usart_line_modes.sv
// Purpose: self-checking bench for the line-mode block
// Assumes: engine side driven here, pins by the far-end model
// Notes:   clk_en tied high, so the freeze path goes untested
`timescale 1ns/100ps
module tb_usart_line_modes;
  logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid;
  logic arready, rvalid, txd_pin, rts_pin, dtr_pin, change_event, rxd_pin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  ulm_pkg::ulm_modem_t modem_pins;
  ulm_pkg::ulm_eng_in_t eng_in = 20'hC0000;
  ulm_pkg::ulm_eng_out_t eng_out;
  int mismatches = 0, tests_run = 0, cyc = 0;
  ulm_line_modes uut (.*);
  ulm_far_end far (.aclk(aclk), .rxd_pin(rxd_pin), .modem_pins(modem_pins));
  always #20 aclk = ~aclk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk)
    if (++cyc == 20000)
    begin
      mismatches++;
      give_verdict;
    end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rv = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic t_ir;
    int d[2];
    int n;
    rd(ulm_pkg::OFF_CLOCK_RATIO);
    chk(rv, 32'h174);
    rd(8'h30);
    chk(rs, ulm_pkg::RESP_SLVERR);
    wr(ulm_pkg::OFF_BAUD_DIVIDER, 32'h1);
    wr(ulm_pkg::OFF_LINE_MODE, 32'h8);
    for (int i = 0; i < 2; i++)
    begin
      wr(ulm_pkg::OFF_INFRARED_FILTER, 32'h4 << i);
      far.pulse(2);
      n = 0;
      repeat (30) @(posedge aclk) n += (eng_out.rx_serial !== 1'h1);
      chk(n, 0);
      far.pulse(12 + 4 * i);
      for (n = 0; eng_out.rx_serial !== 1'h0 && n < 60; n++) @(posedge aclk);
      d[i] = n;
      for (n = 0; eng_out.rx_serial === 1'h0 && n < 60; n++) @(posedge aclk);
      chk(n, 16);
    end
    chk(d[1] - d[0], 4);
    $display("done infrared");
  endtask
  task automatic t_rs485;
    wr(ulm_pkg::OFF_LINE_MODE, 32'h1);
    wr(ulm_pkg::OFF_TX_TIMEGUARD, 32'h2);
    eng_in.tx_empty <= 1'h0;
    w(6);
    chk(rts_pin, 1'h1);
    eng_in.tx_empty <= 1'h1;
    // Tail ends on the second bit end, which may come 17 cycles on
    w(10);
    chk(rts_pin, 1'h1);
    w(60);
    chk(rts_pin, 1'h0);
    $display("done rs485");
  endtask
  task automatic t_modem;
    wr(ulm_pkg::OFF_LINE_MODE, 32'h3);
    wr(ulm_pkg::OFF_LINE_CONTROL, 32'h10040);
    w(4);
    chk({dtr_pin, rts_pin}, 2'h0);
    wr(ulm_pkg::OFF_LINE_CONTROL, 32'h20000);
    w(4);
    chk(dtr_pin, 1'h1);
    rd(ulm_pkg::OFF_CHANNEL_STATUS);
    wr(ulm_pkg::OFF_IRQ_ENABLE, 32'h20000);
    far.lines(1'h1, 4'h2);
    w(6);
    chk(change_event, 1'h1);
    rd(ulm_pkg::OFF_CHANNEL_STATUS);
    chk(rv[19:16], 4'h2);
    rd(ulm_pkg::OFF_CHANNEL_STATUS);
    chk(rv[19:16], 4'h0);
    w(2);
    chk(change_event, 1'h0);
    eng_in.tx_busy <= 1'h1;
    far.lines(1'h1, 4'hA);
    w(8);
    chk(eng_out.tx_enable, 1'h1);
    eng_in.tx_busy <= 1'h0;
    w(6);
    chk(eng_out.tx_enable, 1'h0);
    $display("done modem");
  endtask
  task automatic t_chan;
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 2; b++)
      begin
        far.lines(b[0], 4'hA);
        eng_in.tx_serial <= !b[0];
        wr(ulm_pkg::OFF_LINE_MODE, m << 14);
        w(6);
        chk(txd_pin, m == 0 ? !b[0] : m == 2 ? 1'h1 : b[0]);
        if (m < 3)
          chk(eng_out.rx_serial, m == 2 ? !b[0] : b[0]);
      end
    wr(ulm_pkg::OFF_LINE_MODE, 32'h0);
    wr(ulm_pkg::OFF_LINE_CONTROL, 32'h40000);
    w(4);
    chk(rts_pin, 1'h0);
    $display("done channel");
  endtask
  initial
  begin
    w(8);
    aresetn <= 1'h1;
    w(2);
    t_ir;
    t_rs485;
    t_modem;
    t_chan;
    give_verdict;
  end
endmodule
